// ---- verilog/serp_pkg.sv ----
// constants, field positions and state type for the serial eeprom read path
package serp_pkg;
  localparam int ADDR_W = 8;
  localparam int OFFSET_W = 4;
  localparam int CS_W = 3;
  // device address byte layout
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int CS_HI = 3;
  localparam int CS_LO = 1;
  localparam int RW_BIT = 0;
  // word address byte layout
  localparam int REGION_HI = 7;
  localparam int REGION_LO = 6;
  localparam int OFFSET_HI = 3;
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_SPECIAL = 4'hb;
  localparam logic [1:0] REGION_ID = 2'h0;
  localparam logic [1:0] REGION_LOCK = 2'h1;
  localparam logic [1:0] REGION_UID = 2'h2;
  localparam logic [1:0] REGION_SWP = 2'h3;
  localparam logic [6:0] SWP_PAD = 7'h00;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_SECOND = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [3:0] OFFSET_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [3:0] OFFSET_STEP = 4'h1;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADDR, ST_DEVACK, ST_WORDADDR, ST_WORDACK,
    ST_WDATA, ST_WDACK, ST_RDATA, ST_RDACK
  } serp_state_t;
endpackage

// ---- verilog/serp_sync.sv ----
// two flip-flop synchroniser for slow levels entering a clock domain
`timescale 1ns/1ps
module serp_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule // serp_sync

// ---- verilog/serp_read_path.sv ----
// two-wire serial eeprom target: read commands, shared address counter, special regions
// What this block does
// - read header: type code, select pins, read bit, acknowledge
// - reads ignore both write protect sources
// - current read sends counter byte, then increments
// - address counter survives between bus operations
// - main array wraps from last to first byte
// - one counter shared; special access loads offset
// - keep sending bytes while master acknowledges
// - identification_page read: type 1011, region 00
// - identification_page reads wrap within the page
// - lock probe: data ack when unlocked, nack locked
// - start after probe resets logic; stop idles
// - flag read: region 11, seven zeros, flag
// - repeated flag bytes while master keeps acknowledging
// - serial number read: region 10, offset nibble
// - serial number block is never writable
// - serial number wraps after sixteen bytes
`timescale 1ns/1ps
module serp_read_path #(
  parameter int MEM_DEPTH = 256,
  parameter int PAGE_BYTES = 16,
  parameter logic [127:0] UID_VALUE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0 // arbitrary value
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic chip_select_pin_hi,
  input wire logic chip_select_pin_mid,
  input wire logic chip_select_pin_lo,
  input wire logic software_write_protect_flag,
  input wire logic identification_page_locked,
  input wire logic mem_wr_en,
  input wire logic mem_wr_identification_page,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  output logic link_busy
);
  if (MEM_DEPTH != (1 << serp_pkg::ADDR_W) || PAGE_BYTES != (1 << serp_pkg::OFFSET_W)) begin : g_bad_size
    $error("serp_read_path: array sizes must match the 8-bit counter and 4-bit offset");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // storage, written from the system side by the write path
  logic [7:0] mem_r [0:MEM_DEPTH-1];
  logic [7:0] id_mem_r [0:PAGE_BYTES-1];

  // the serial number has no write port at all, so nothing can alter it
  always_ff @(posedge clock) begin
    if (clk_en && mem_wr_en) begin
      if (mem_wr_identification_page) begin
        id_mem_r[mem_wr_addr[serp_pkg::OFFSET_HI:0]] <= mem_wr_data;
      end else begin
        mem_r[mem_wr_addr] <= mem_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // levels entering the link domain
  logic ce_s;
  logic swp_s;
  logic locked_s;
  logic [2:0] cs_s;

  serp_sync #(.W(6)) u_link_sync (
    .clock(scl),
    .d({clk_en, software_write_protect_flag, identification_page_locked,
        chip_select_pin_hi, chip_select_pin_mid, chip_select_pin_lo}),
    .q({ce_s, swp_s, locked_s, cs_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // start and stop detection: sda edges while scl is high
  logic start_tgl_r;
  logic stop_tgl_r;

  // the link clock stops between frames, so these run on the data line itself
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tgl_r <= 1'b0;
    end else if (scl) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end
  always_ff @(posedge sda_in or posedge reset) begin
    if (reset) begin
      stop_tgl_r <= 1'b0;
    end else if (scl) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: byte framing state machine
  serp_pkg::serp_state_t st_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic start_seen_r;
  logic ack_r;
  logic is_read_r;
  logic special_r;
  logic [1:0] region_r;
  logic [7:0] addr_cnt_r;
  logic [7:0] tx_r;
  logic sda_oe_n_r;
  logic [7:0] rx_byte;
  logic start_pend;
  logic dev_match;
  logic load_byte;
  logic drive_low;
  logic [7:0] rd_byte;

  // byte fetch for the region in use; protection plays no part here
  function automatic logic [7:0] fetch_byte(input logic sp, input logic [1:0] rg, input logic [7:0] a);
    logic [3:0] off;
    off = a[serp_pkg::OFFSET_HI:0];
    if (!sp) begin
      fetch_byte = mem_r[a];
    end else if (rg == serp_pkg::REGION_SWP) begin
      fetch_byte = {serp_pkg::SWP_PAD, swp_s};
    end else if (rg == serp_pkg::REGION_UID) begin
      fetch_byte = UID_VALUE[(5'd15 - 5'(off)) * 8 +: 8]; // offset zero is the first byte sent
    end else begin
      fetch_byte = id_mem_r[off];
    end
  endfunction

  // counter advance: full 8-bit wrap for the array, offset-only wrap for page and serial number, flag holds
  function automatic logic [7:0] next_addr(input logic sp, input logic [1:0] rg, input logic [7:0] a);
    if (!sp) begin
      next_addr = a + serp_pkg::ADDR_STEP;
    end else if (rg == serp_pkg::REGION_SWP) begin
      next_addr = a;
    end else begin
      next_addr = {a[7:4], a[serp_pkg::OFFSET_HI:0] + serp_pkg::OFFSET_STEP};
    end
  endfunction
  assign rx_byte = {rx_r[6:0], sda_in};
  assign start_pend = start_tgl_r != start_seen_r;
  // write protect is absent from the match on purpose
  assign dev_match = (rx_byte[serp_pkg::TYPE_HI:serp_pkg::TYPE_LO] == serp_pkg::TYPE_MEM ||
                      rx_byte[serp_pkg::TYPE_HI:serp_pkg::TYPE_LO] == serp_pkg::TYPE_SPECIAL) &&
                     rx_byte[serp_pkg::CS_HI:serp_pkg::CS_LO] == cs_s;
  assign load_byte = !start_pend && ((st_r == serp_pkg::ST_DEVACK && ack_r && is_read_r) ||
                                     (st_r == serp_pkg::ST_RDACK && !sda_in));
  always_comb rd_byte = fetch_byte(special_r, region_r, addr_cnt_r); // an assign would miss array and flag updates

  // a start wins over any state, which drops a truncated write
  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      st_r <= serp_pkg::ST_IDLE;
      bit_cnt_r <= serp_pkg::BIT_FIRST;
      rx_r <= serp_pkg::BYTE_ZERO;
      start_seen_r <= 1'b0;
      ack_r <= 1'b0;
      is_read_r <= 1'b0;
      special_r <= 1'b0;
    end else if (ce_s) begin
      start_seen_r <= start_tgl_r;
      if (start_pend) begin
        st_r <= serp_pkg::ST_DEVADDR;
        bit_cnt_r <= serp_pkg::BIT_SECOND;
        rx_r <= {7'h00, sda_in};
      end else begin
        case (st_r)
          serp_pkg::ST_DEVADDR: begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == serp_pkg::BIT_LAST) begin
              st_r <= serp_pkg::ST_DEVACK;
              ack_r <= dev_match;
              is_read_r <= rx_byte[serp_pkg::RW_BIT];
              special_r <= rx_byte[serp_pkg::TYPE_HI:serp_pkg::TYPE_LO] == serp_pkg::TYPE_SPECIAL;
            end
          end
          serp_pkg::ST_DEVACK: begin
            bit_cnt_r <= serp_pkg::BIT_FIRST;
            if (!ack_r) begin
              st_r <= serp_pkg::ST_IDLE;
            end else if (is_read_r) begin
              st_r <= serp_pkg::ST_RDATA;
            end else begin
              st_r <= serp_pkg::ST_WORDADDR;
            end
          end
          serp_pkg::ST_WORDADDR: begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == serp_pkg::BIT_LAST) begin
              st_r <= serp_pkg::ST_WORDACK;
              ack_r <= 1'b1;
            end
          end
          serp_pkg::ST_WORDACK: begin
            st_r <= serp_pkg::ST_WDATA;
            bit_cnt_r <= serp_pkg::BIT_FIRST;
          end
          serp_pkg::ST_WDATA: begin
            rx_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == serp_pkg::BIT_LAST) begin
              st_r <= serp_pkg::ST_WDACK;
              // the lock probe answers with the page's lock state
              ack_r <= !(special_r && region_r == serp_pkg::REGION_ID && locked_s);
            end
          end
          serp_pkg::ST_WDACK: begin
            // programming belongs to the write path; here the frame just waits
            st_r <= serp_pkg::ST_IDLE;
          end
          serp_pkg::ST_RDATA: begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == serp_pkg::BIT_LAST) begin
              st_r <= serp_pkg::ST_RDACK;
            end
          end
          serp_pkg::ST_RDACK: begin
            bit_cnt_r <= serp_pkg::BIT_FIRST;
            st_r <= sda_in ? serp_pkg::ST_IDLE : serp_pkg::ST_RDATA;
          end
          default: begin
            st_r <= serp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared address counter, region and transmit shifter
  // only reset clears the counter, so it persists across frames
  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      addr_cnt_r <= serp_pkg::ADDR_RESET;
      region_r <= serp_pkg::REGION_ID;
      tx_r <= serp_pkg::BYTE_ZERO;
    end else if (ce_s && !start_pend) begin
      if (st_r == serp_pkg::ST_WORDADDR && bit_cnt_r == serp_pkg::BIT_LAST) begin
        if (!special_r) begin
          addr_cnt_r <= rx_byte;
        end else begin
          region_r <= rx_byte[serp_pkg::REGION_HI:serp_pkg::REGION_LO];
          if (rx_byte[serp_pkg::REGION_HI:serp_pkg::REGION_LO] == serp_pkg::REGION_ID ||
              rx_byte[serp_pkg::REGION_HI:serp_pkg::REGION_LO] == serp_pkg::REGION_UID) begin
            addr_cnt_r <= {serp_pkg::OFFSET_ZERO, rx_byte[serp_pkg::OFFSET_HI:0]};
          end
        end
      end else if (load_byte) begin
        tx_r <= rd_byte;
        addr_cnt_r <= next_addr(special_r, region_r, addr_cnt_r);
      end else if (st_r == serp_pkg::ST_RDATA) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data line drive, changed only while scl is low
  assign drive_low = !start_pend &&
                     (((st_r == serp_pkg::ST_DEVACK || st_r == serp_pkg::ST_WORDACK ||
                        st_r == serp_pkg::ST_WDACK) && ack_r) ||
                      (st_r == serp_pkg::ST_RDATA && !tx_r[7]));

  // idle and the master's ack slot leave the line released
  always_ff @(negedge scl or posedge reset) begin
    if (reset) begin
      sda_oe_n_r <= 1'b1;
    end else if (ce_s) begin
      sda_oe_n_r <= !drive_low;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe_n = sda_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////////
  // system domain: frame activity seen through the toggles
  logic start_sys;
  logic stop_sys;
  logic start_prev_r;
  logic stop_prev_r;
  logic link_busy_r;

  serp_sync #(.W(2)) u_sys_sync (
    .clock(clock),
    .d({start_tgl_r, stop_tgl_r}),
    .q({start_sys, stop_sys})
  );

  // a start seen in the same cycle as a stop leaves the link busy
  always_ff @(posedge clock) begin
    if (reset) begin
      start_prev_r <= 1'b0;
      stop_prev_r <= 1'b0;
      link_busy_r <= 1'b0;
    end else if (clk_en) begin
      start_prev_r <= start_sys;
      stop_prev_r <= stop_sys;
      if (start_sys != start_prev_r) begin
        link_busy_r <= 1'b1;
      end else if (stop_sys != stop_prev_r) begin
        link_busy_r <= 1'b0;
      end
    end
  end
  assign link_busy = link_busy_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the link domain
  addr_ack_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && !start_pend && st_r == serp_pkg::ST_DEVADDR && bit_cnt_r == serp_pkg::BIT_LAST)
    |=> (st_r == serp_pkg::ST_DEVACK && ack_r == $past(dev_match)))
    else $error("device address ack does not follow the header match");
  read_data_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && load_byte && !special_r) |=> tx_r == $past(mem_r[addr_cnt_r]))
    else $error("read byte differs from array contents");
  count_step_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && load_byte && !special_r) |=> addr_cnt_r == $past(addr_cnt_r) + serp_pkg::ADDR_STEP)
    else $error("counter did not advance by one after a read byte");
  mem_wrap_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && load_byte && !special_r && addr_cnt_r == 8'hff) |=> addr_cnt_r == serp_pkg::ADDR_RESET)
    else $error("array read did not wrap to the first byte");
  offset_load_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && !start_pend && special_r && st_r == serp_pkg::ST_WORDADDR && bit_cnt_r == serp_pkg::BIT_LAST &&
     rx_byte[serp_pkg::REGION_HI:serp_pkg::REGION_LO] == serp_pkg::REGION_ID)
    |=> addr_cnt_r == {serp_pkg::OFFSET_ZERO, $past(rx_byte[serp_pkg::OFFSET_HI:0])})
    else $error("identification_page offset not loaded into the counter");
  ack_continue_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && !start_pend && st_r == serp_pkg::ST_RDACK && !sda_in)
    |=> (st_r == serp_pkg::ST_RDATA && bit_cnt_r == serp_pkg::BIT_FIRST))
    else $error("master ack did not start the next byte");
  page_wrap_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && load_byte && special_r && region_r != serp_pkg::REGION_SWP && addr_cnt_r[3:0] == 4'hf)
    |=> (addr_cnt_r[3:0] == serp_pkg::OFFSET_ZERO && $stable(addr_cnt_r[7:4])))
    else $error("special region read left its sixteen bytes");
  lock_probe_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && !start_pend && st_r == serp_pkg::ST_WDATA && bit_cnt_r == serp_pkg::BIT_LAST &&
     special_r && region_r == serp_pkg::REGION_ID) |=> ack_r == !$past(locked_s))
    else $error("lock probe answer does not match the lock state");
  flag_repeat_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && load_byte && special_r && region_r == serp_pkg::REGION_SWP)
    |=> (tx_r == {serp_pkg::SWP_PAD, $past(swp_s)} && $stable(addr_cnt_r)))
    else $error("flag byte wrong or counter moved");
  nack_release_a: assert property (@(posedge scl) disable iff (reset)
    (ce_s && !start_pend && st_r == serp_pkg::ST_RDACK && sda_in)
    |=> (st_r == serp_pkg::ST_IDLE) ##1 sda_oe_n_r)
    else $error("data line still driven after master nack");

  seq_read_c: cover property (@(posedge scl) disable iff (reset)
    st_r == serp_pkg::ST_RDACK && !sda_in && !special_r);
  uid_read_c: cover property (@(posedge scl) disable iff (reset)
    load_byte && special_r && region_r == serp_pkg::REGION_UID);
  probe_nack_c: cover property (@(posedge scl) disable iff (reset)
    st_r == serp_pkg::ST_WDACK && !ack_r);
  flag_read_c: cover property (@(posedge scl) disable iff (reset)
    load_byte && special_r && region_r == serp_pkg::REGION_SWP);
endmodule // serp_read_path

// ---- verification/serp_master_model.sv ----
// two-wire bus master model: start, stop and byte transfers on a link clock that rests between frames
`timescale 1ns/1ps
module serp_master_model (
  input wire logic sda,
  output logic scl,
  output logic sda_pull_n
);
  // 64 ns link period; scl stands high outside frames
  localparam time HALF = 32;

  // released wire and idle clock at time zero
  initial begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_pull_n = 1'b1;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) sda_pull_n = 1'b0;
    #(HALF/2) scl = 1'b0;
    #(HALF/2);
  endtask

  // stop: data rises while the clock is high, then the clock stands still
  task automatic stop_cond();
    sda_pull_n = 1'b0;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) sda_pull_n = 1'b1;
    #HALF;
  endtask

  // one bit: data only changes while scl is low, sampled mid-high
  task automatic clock_bit(input logic b, output logic r);
    sda_pull_n = b;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) r = sda;
    #(HALF/2) scl = 1'b0;
    #(HALF/2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // byte out msb first, then release for the device acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = ~r;
  endtask

  // byte in; withholding the acknowledge ends the read
  task automatic read_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      clock_bit(1'b1, r);
      d = {d[6:0], r};
    end
    clock_bit(~more, r);
  endtask
endmodule // serp_master_model

// ---- verification/serp_read_path_tb_top.sv ----
// self-checking bench for the serial eeprom read path
`timescale 1ns/1ps
`define SERP_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module serp_read_path_tb_top;
  localparam logic [127:0] UID_TB = 128'h00112233445566778899aabbccddeeff; // arbitrary value
  localparam logic [2:0] CS_TB = 3'h5;
  localparam int LIMIT = 20000;
  logic clock, reset, clk_en, scl, sda, sda_pull_n, sda_out, sda_oe_n, link_busy;
  logic sw_flag, locked, mem_wr_en, mem_wr_identification_page, ack;
  logic [7:0] mem_wr_addr, mem_wr_data, rd;
  logic [2:0] cs_pins;
  int fails, checked, cycles;

  // pull-up wire pulled low by either party
  assign sda = (sda_oe_n | sda_out) & sda_pull_n;

  serp_read_path #(.UID_VALUE(UID_TB)) u_dut (
    .clock(clock), .reset(reset), .clk_en(clk_en), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_pin_hi(cs_pins[2]),
    .chip_select_pin_mid(cs_pins[1]), .chip_select_pin_lo(cs_pins[0]),
    .software_write_protect_flag(sw_flag), .identification_page_locked(locked), .mem_wr_en(mem_wr_en),
    .mem_wr_identification_page(mem_wr_identification_page), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .link_busy(link_busy)
  );

  serp_master_model u_master (.sda(sda), .scl(scl), .sda_pull_n(sda_pull_n));

  ////////////////////////////////////////////////////////////////////////////////
  // preload patterns, chosen so that neighbours always differ
  function automatic logic [7:0] mem_val(input logic [7:0] a); return a ^ 8'h5a; endfunction
  function automatic logic [7:0] id_val(input logic [3:0] i); return {4'h3, i}; endfunction
  function automatic logic [7:0] uid_b(input logic [3:0] i); return UID_TB[127 - 8*i -: 8]; endfunction

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // device address byte; the device must answer and report the link busy
  task automatic head(input logic [3:0] kind, input logic rw);
    u_master.start_cond();
    u_master.write_byte({kind, CS_TB, rw}, ack);
    `SERP_CHK(ack, 1'b1)
    `SERP_CHK(link_busy, 1'b1)
  endtask

  // dummy write loads the word address, repeated start opens the read
  task automatic open_rd(input logic [3:0] kind, input logic [7:0] word);
    head(kind, 1'b0);
    u_master.write_byte(word, ack);
    `SERP_CHK(ack, 1'b1)
    head(kind, 1'b1);
  endtask

  // one read byte; after the refused last one the wire must be let go
  task automatic rd_chk(input logic [7:0] exp, input logic last);
    u_master.read_byte(~last, rd);
    `SERP_CHK(rd, exp)
    if (last) begin
      `SERP_CHK(sda_oe_n, 1'b1)
    end
  endtask

  // stop, then the system side must see the link idle within a few clocks
  task automatic stop_chk();
    u_master.stop_cond();
    repeat (8) @(negedge clock);
    `SERP_CHK(link_busy, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always #50 clock = ~clock;

  // hang guard; the whole run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    clock = 1'b0;
    reset = 1'b0;
    clk_en = 1'b1;
    cs_pins = CS_TB;
    sw_flag = 1'b1;
    locked = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_identification_page = 1'b0;
    mem_wr_addr = 8'h00;
    mem_wr_data = 8'h00;
    // rise after time zero so the asynchronous link flops see a real edge
    #1;
    reset = 1'b1;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    // back to back preload of the array, then the identification_page
    for (int i = 0; i < 272; i++) begin
      @(negedge clock);
      mem_wr_en = 1'b1;
      mem_wr_identification_page = (i >= 256);
      mem_wr_addr = i[7:0];
      mem_wr_data = (i >= 256) ? id_val(i[3:0]) : mem_val(i[7:0]);
    end
    // a strobe while frozen must not land; the page select is still set, so it aims at identification_page byte 2, which no read below checks
    @(negedge clock);
    clk_en = 1'b0;
    mem_wr_addr = 8'h02;
    mem_wr_data = 8'hff;
    @(negedge clock);
    clk_en = 1'b1;
    mem_wr_en = 1'b0;
    // foreign type code, then a wrong select field, both ignored
    u_master.start_cond();
    u_master.write_byte(8'h5b, ack);
    u_master.start_cond();
    u_master.write_byte({4'ha, ~CS_TB, 1'b1}, ack);
    `SERP_CHK(ack, 1'b0)
    stop_chk();
    // sequential read over the top of the array with protection set
    open_rd(4'ha, 8'hfe);
    for (int i = 0; i < 4; i++) begin
      rd_chk(mem_val(8'hfe + i[7:0]), i == 3);
    end
    stop_chk();
    // plain read continues from the counter kept across operations
    head(4'ha, 1'b1);
    rd_chk(mem_val(8'h02), 1'b1);
    stop_chk();
    // identification_page read wraps inside the page and moves the shared counter
    open_rd(4'hb, 8'h0e);
    rd_chk(id_val(4'he), 1'b0);
    rd_chk(id_val(4'hf), 1'b0);
    rd_chk(id_val(4'h0), 1'b1);
    stop_chk();
    head(4'ha, 1'b1);
    rd_chk(mem_val(8'h01), 1'b1);
    stop_chk();
    // flag read for both flag levels, repeated while acknowledged
    for (int f = 0; f < 2; f++) begin
      @(negedge clock);
      sw_flag = f[0];
      open_rd(4'hb, 8'hc5);
      for (int k = 0; k < 3; k++) begin
        rd_chk({7'h00, f[0]}, k == 2);
      end
      stop_chk();
    end
    // whole serial number from offset zero, ignored bits set, plus one wrapped byte
    open_rd(4'hb, 8'hb0);
    for (int i = 0; i < 17; i++) begin
      rd_chk(uid_b(i[3:0]), i == 16);
    end
    stop_chk();
    // lock probe unlocked and locked, then a write aimed at the serial number
    for (int l = 0; l < 3; l++) begin
      @(negedge clock);
      locked = (l == 1);
      head(4'hb, 1'b0);
      u_master.write_byte((l == 2) ? 8'h80 : 8'h00, ack);
      u_master.write_byte(8'h77, ack);
      if (l < 2) begin
        `SERP_CHK(ack, ~locked)
      end
      u_master.start_cond();
      // keep start and stop apart so the system side sees them in separate cycles
      repeat (3) @(negedge clock);
      stop_chk();
    end
    // neither the truncated page write nor the serial number write took effect
    open_rd(4'hb, 8'h00);
    rd_chk(id_val(4'h0), 1'b1);
    stop_chk();
    open_rd(4'hb, 8'h80);
    rd_chk(uid_b(4'h0), 1'b1);
    stop_chk();
    tally_and_finish();
  end
endmodule // serp_read_path_tb_top
